//--- logic/asbdc_pkg.sv
// Function
// - buffer arbitration fixed priority: usb manager, then drive engine, then microcontroller
// - buffer size selectable as 8K, 24K or 32K bytes only
// - microcontroller reaches buffer only via indirect address pair and data byte registers
// - sector data flows in one direction at a time
// - automatic mode: engine moves buffer data to or from drive without microcontroller
// - manual mode: microcontroller data byte writes go to drive port; drive port data never reaches the microcontroller
// - command end raises interrupt with completion or error indication
// - transaction machine sequences commands and launches the two data engines
// - one engine does PIO and multiword DMA transfers
// - separate engine does ultra DMA transfers
// - sixteen drive command registers feed the drive in both automatic and manual modes
// - sixteen configuration registers hold mode, timing, byte count and lengths
// - twenty-six status registers incl. interrupt, indirect access and error handling
package asbdc_pkg;
	localparam int ADDR_W = 15;
	localparam int CMD_REGS = 16;
	localparam int CFG_REGS = 16;
	localparam int STS_REGS = 26;
	localparam logic [1:0] SIZE_8K = 2'h0;
	localparam logic [1:0] SIZE_24K = 2'h1;
	localparam logic [1:0] SIZE_32K = 2'h2;
	localparam logic [ADDR_W-1:0] LIM_8K = 15'h1FFF;
	localparam logic [ADDR_W-1:0] LIM_24K = 15'h5FFF;
	localparam logic [ADDR_W-1:0] LIM_32K = 15'h7FFF;
	localparam logic [3:0] CFG_MODE = 4'h0;
	localparam logic [3:0] CFG_CNT_LO = 4'h1;
	localparam logic [3:0] CFG_CNT_HI = 4'h2;
	localparam logic [4:0] STS_STATE = 5'h00;
	localparam logic [4:0] STS_ERR = 5'h01;
	localparam logic [4:0] STS_ADR_LO = 5'h02;
	localparam logic [4:0] STS_ADR_HI = 5'h03;
	localparam logic [4:0] STS_DATA = 5'h04;
	localparam int MODE_UDMA_BIT = 0;
	localparam int MODE_MDMA_BIT = 1;
	localparam int MODE_AUTO_BIT = 2;
	localparam int MODE_DIR_BIT = 3;
	typedef enum logic [4:0] {
		TR_IDLE = 5'h01,
		TR_CMD  = 5'h02,
		TR_DATA = 5'h04,
		TR_DONE = 5'h08,
		TR_ERR  = 5'h10
	} asbdc_tr_type;
	typedef enum logic [3:0] {
		EN_IDLE = 4'h1,
		EN_REQ  = 4'h2,
		EN_XFER = 4'h4,
		EN_END  = 4'h8
	} asbdc_en_type;
endpackage : asbdc_pkg

//--- logic/asbdc_ram.sv
`timescale 1ns/1ps
module asbdc_ram #(
	parameter int AW = 15
) (
	input  wire logic          ref_clk_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [7:0]    wdata_i,
	output logic      [7:0]    rdata_o
);
	logic [7:0] mem [0:(1<<AW)-1];
	always_ff @(posedge ref_clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule : asbdc_ram

//--- logic/asbdc_ctrl.sv
`timescale 1ns/1ps
module asbdc_ctrl #(
	parameter int AW = asbdc_pkg::ADDR_W
) (
	input  wire logic          ref_clk_i,
	input  wire logic          resetn_i,
	input  wire logic [1:0]    size_sel_i,
	input  wire logic          ubm_req_i,
	input  wire logic          ubm_we_i,
	input  wire logic [AW-1:0] ubm_addr_i,
	input  wire logic [7:0]    ubm_wdata_i,
	output logic               ubm_gnt_o,
	output logic [7:0]         rdata_o,
	input  wire logic          mcu_wr_i,
	input  wire logic          mcu_rd_i,
	input  wire logic [1:0]    mcu_grp_i,
	input  wire logic [4:0]    mcu_idx_i,
	input  wire logic [7:0]    mcu_wdata_i,
	output logic [7:0]         mcu_rdata_o,
	input  wire logic          start_i,
	output logic               irq_o,
	output logic               irq_err_o,
	input  wire logic          drv_rdy_i,
	input  wire logic          drv_err_i,
	input  wire logic [7:0]    drv_din_i,
	output logic [7:0]         drv_dout_o,
	output logic               drv_oe_o,
	output logic               drv_pio_stb_o,
	output logic               drv_udma_stb_o,
	output logic [3:0]         drv_cmd_idx_o
);
	// drive pins come from outside, two stages before use
	logic [9:0] sy1_r, sy2_r;
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			sy1_r <= 10'h000;
			sy2_r <= 10'h000;
		end else begin
			sy1_r <= {drv_rdy_i, drv_err_i, drv_din_i};
			sy2_r <= sy1_r;
		end
	end
	wire       rdy_s = sy2_r[9];
	wire       err_s = sy2_r[8];
	wire [7:0] din_s = sy2_r[7:0];

	logic [7:0] cmd_r [asbdc_pkg::CMD_REGS];
	logic [7:0] cfg_r [asbdc_pkg::CFG_REGS];
	logic [7:0] sts_r [asbdc_pkg::STS_REGS];
	logic [AW-1:0] mptr_r;
	logic [AW-1:0] eptr_r;
	logic [15:0] cnt_r;
	asbdc_pkg::asbdc_tr_type tr_r;
	asbdc_pkg::asbdc_en_type pio_r, udma_r;

	function automatic logic [AW-1:0] lim_f(input logic [1:0] s);
		if (s == asbdc_pkg::SIZE_8K) lim_f = asbdc_pkg::LIM_8K;
		else if (s == asbdc_pkg::SIZE_24K) lim_f = asbdc_pkg::LIM_24K;
		else lim_f = asbdc_pkg::LIM_32K;
	endfunction : lim_f
	wire [AW-1:0] lim = lim_f(size_sel_i);

	wire [7:0] mode = cfg_r[asbdc_pkg::CFG_MODE];
	wire auto_m = mode[asbdc_pkg::MODE_AUTO_BIT];
	wire dir_w = mode[asbdc_pkg::MODE_DIR_BIT]; // 1: drive to buffer
	wire eng_on = (pio_r == asbdc_pkg::EN_XFER) || (udma_r == asbdc_pkg::EN_XFER);
	// no buffer access once the count is spent, so the last byte is not written or strobed twice
	wire eng_req = eng_on && auto_m && rdy_s && (cnt_r != 16'h0000);
	wire mcu_req = (mcu_wr_i || mcu_rd_i) && mcu_grp_i == 2'h2 && mcu_idx_i == asbdc_pkg::STS_DATA;
	// fixed priority; a lower requester simply waits, no queuing
	wire g_ubm = ubm_req_i;
	wire g_eng = eng_req && !ubm_req_i;
	wire g_mcu = mcu_req && !ubm_req_i && !eng_req;
	// half-duplex: while an engine runs, the ubm writes only when the drive side reads and vice versa
	wire ubm_ok = !eng_on || (ubm_we_i != dir_w);

	logic ram_we;
	logic [AW-1:0] ram_a;
	logic [7:0] ram_wd, ram_rd;
	always_comb begin
		ram_we = 1'b0;
		ram_a = mptr_r & lim;
		ram_wd = mcu_wdata_i;
		if (g_ubm) begin
			ram_we = ubm_we_i && ubm_ok;
			ram_a = ubm_addr_i & lim;
			ram_wd = ubm_wdata_i;
		end else if (g_eng) begin
			ram_we = dir_w;
			ram_a = eptr_r;
			ram_wd = din_s;
		end else if (g_mcu) begin
			ram_we = mcu_wr_i;
		end
	end
	asbdc_ram #(.AW(AW)) u_ram (
		.ref_clk_i (ref_clk_i),
		.we_i      (ram_we),
		.addr_i    (ram_a),
		.wdata_i   (ram_wd),
		.rdata_o   (ram_rd)
	);
	logic eng_rd_d;
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			ubm_gnt_o <= 1'b0;
			eng_rd_d <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			ubm_gnt_o <= g_ubm && ubm_ok;
			eng_rd_d <= g_eng && !dir_w;
			rdata_o <= ram_rd;
		end
	end

	// register groups; mcu writes win over none since hardware only writes status
	wire xfer_end = eng_on && (cnt_r == 16'h0000);
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < asbdc_pkg::CMD_REGS; i++) cmd_r[i] <= 8'h00;
			for (int i = 0; i < asbdc_pkg::CFG_REGS; i++) cfg_r[i] <= 8'h00;
		end else if (mcu_wr_i && mcu_grp_i == 2'h0) begin
			cmd_r[mcu_idx_i[3:0]] <= mcu_wdata_i;
		end else if (mcu_wr_i && mcu_grp_i == 2'h1) begin
			cfg_r[mcu_idx_i[3:0]] <= mcu_wdata_i;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < asbdc_pkg::STS_REGS; i++) sts_r[i] <= 8'h00;
		end else begin
			for (int i = 0; i < asbdc_pkg::STS_REGS; i++) begin
				if (mcu_wr_i && mcu_grp_i == 2'h2 && mcu_idx_i == 5'(i) && i != asbdc_pkg::STS_STATE)
					sts_r[i] <= mcu_wdata_i;
			end
			sts_r[asbdc_pkg::STS_STATE] <= {3'h0, tr_r};
			if (err_s && eng_on) sts_r[asbdc_pkg::STS_ERR] <= 8'h01; // set wins over clear
		end
	end
	// indirect pointer from address pair, post-incremented per data access
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			mptr_r <= '0;
		end else if (g_mcu) begin
			mptr_r <= (mptr_r + 1'b1) & lim;
		end else if (mcu_wr_i && mcu_grp_i == 2'h2 && mcu_idx_i == asbdc_pkg::STS_ADR_LO) begin
			// loaded only on an address write, so the post-increment survives between data accesses
			mptr_r <= {mptr_r[AW-1:8], mcu_wdata_i} & lim;
		end else if (mcu_wr_i && mcu_grp_i == 2'h2 && mcu_idx_i == asbdc_pkg::STS_ADR_HI) begin
			mptr_r <= {mcu_wdata_i[AW-9:0], mptr_r[7:0]} & lim;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			mcu_rdata_o <= 8'h00;
		end else if (mcu_grp_i == 2'h0) begin
			mcu_rdata_o <= cmd_r[mcu_idx_i[3:0]];
		end else if (mcu_grp_i == 2'h1) begin
			mcu_rdata_o <= cfg_r[mcu_idx_i[3:0]];
		end else if (mcu_idx_i == asbdc_pkg::STS_DATA) begin
			mcu_rdata_o <= ram_rd;
		end else if (mcu_idx_i < 5'(asbdc_pkg::STS_REGS)) begin
			mcu_rdata_o <= sts_r[mcu_idx_i];
		end else begin
			mcu_rdata_o <= 8'h00;
		end
	end

	// transaction machine
	logic [3:0] cidx_r;
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			tr_r <= asbdc_pkg::TR_IDLE;
			cidx_r <= 4'h0;
			irq_o <= 1'b0;
			irq_err_o <= 1'b0;
		end else begin
			irq_o <= 1'b0;
			case (tr_r)
				asbdc_pkg::TR_IDLE: if (start_i) begin
					tr_r <= asbdc_pkg::TR_CMD;
					cidx_r <= 4'h0;
					irq_err_o <= 1'b0;
				end
				asbdc_pkg::TR_CMD: begin
					if (cidx_r == 4'(asbdc_pkg::CMD_REGS - 1)) tr_r <= asbdc_pkg::TR_DATA;
					cidx_r <= cidx_r + 4'h1;
				end
				asbdc_pkg::TR_DATA: begin
					if (err_s) tr_r <= asbdc_pkg::TR_ERR;
					else if (xfer_end) tr_r <= asbdc_pkg::TR_DONE;
				end
				asbdc_pkg::TR_DONE: begin
					irq_o <= 1'b1;
					tr_r <= asbdc_pkg::TR_IDLE;
				end
				asbdc_pkg::TR_ERR: begin
					irq_o <= 1'b1;
					irq_err_o <= 1'b1;
					tr_r <= asbdc_pkg::TR_IDLE;
				end
				default: tr_r <= asbdc_pkg::TR_IDLE;
			endcase
		end
	end
	// engines: pio/mdma and udma run exclusively, chosen from the mode register
	wire launch = tr_r == asbdc_pkg::TR_CMD && cidx_r == 4'(asbdc_pkg::CMD_REGS - 1);
	wire use_u = mode[asbdc_pkg::MODE_UDMA_BIT];
	wire step = eng_on && (cnt_r != 16'h0000) && (auto_m ? g_eng : (rdy_s && mcu_req));
	function automatic asbdc_pkg::asbdc_en_type en_nxt(input asbdc_pkg::asbdc_en_type s, input logic go,
		input logic fin, input logic ab);
		en_nxt = s;
		case (s)
			asbdc_pkg::EN_IDLE: if (go) en_nxt = asbdc_pkg::EN_REQ;
			asbdc_pkg::EN_REQ: en_nxt = asbdc_pkg::EN_XFER;
			asbdc_pkg::EN_XFER: if (fin || ab) en_nxt = asbdc_pkg::EN_END;
			default: en_nxt = asbdc_pkg::EN_IDLE;
		endcase
	endfunction : en_nxt
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			pio_r <= asbdc_pkg::EN_IDLE;
			udma_r <= asbdc_pkg::EN_IDLE;
		end else begin
			pio_r <= en_nxt(pio_r, launch && !use_u, xfer_end, err_s);
			udma_r <= en_nxt(udma_r, launch && use_u, xfer_end, err_s);
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			cnt_r <= 16'h0000;
			eptr_r <= '0;
		end else if (launch) begin
			cnt_r <= {cfg_r[asbdc_pkg::CFG_CNT_HI], cfg_r[asbdc_pkg::CFG_CNT_LO]};
			eptr_r <= '0;
		end else if (step && cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
			eptr_r <= (eptr_r + 1'b1) & lim;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			drv_dout_o <= 8'h00;
			drv_oe_o <= 1'b0;
			drv_pio_stb_o <= 1'b0;
			drv_udma_stb_o <= 1'b0;
			drv_cmd_idx_o <= 4'h0;
		end else begin
			drv_cmd_idx_o <= cidx_r;
			drv_oe_o <= (tr_r == asbdc_pkg::TR_CMD) || (eng_on && !dir_w);
			if (tr_r == asbdc_pkg::TR_CMD) drv_dout_o <= cmd_r[cidx_r];
			else if (auto_m) drv_dout_o <= ram_rd;
			else drv_dout_o <= mcu_wdata_i;
			// buffer reads land a cycle late, so their strobe follows the data onto the pins
			drv_pio_stb_o <= (pio_r == asbdc_pkg::EN_XFER) && ((dir_w || !auto_m) ? step : eng_rd_d);
			drv_udma_stb_o <= (udma_r == asbdc_pkg::EN_XFER) && ((dir_w || !auto_m) ? step : eng_rd_d);
		end
	end
endmodule : asbdc_ctrl

//--- bench/asbdc_properties.sv
`timescale 1ns/1ps
module asbdc_props (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic ubm_req_i,
	input wire logic ubm_we_i,
	input wire logic ubm_gnt_o,
	input wire logic start_i,
	input wire logic irq_o,
	input wire logic irq_err_o,
	input wire logic drv_oe_o,
	input wire logic drv_pio_stb_o,
	input wire logic drv_udma_stb_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence cmd_out;
		drv_oe_o [*8];
	endsequence
	rst_quiet_a: assert property (disable iff (1'b0) !resetn_i |=> !irq_o && !drv_oe_o && !ubm_gnt_o) else $error("busy out of reset");
	rd_grant_a: assert property (ubm_req_i && !ubm_we_i |=> ubm_gnt_o) else $error("usb read stalled");
	gnt_cause_a: assert property (ubm_gnt_o |-> $past(ubm_req_i)) else $error("grant without request");
	irq_pulse_a: assert property (irq_o |=> !irq_o) else $error("irq longer than a cycle");
	err_with_irq_a: assert property ($rose(irq_err_o) |-> irq_o) else $error("error flag without irq");
	err_clear_a: assert property (start_i |-> ##[1:2] !irq_err_o) else $error("error flag kept");
	one_engine_a: assert property (!(drv_pio_stb_o && drv_udma_stb_o)) else $error("both engines strobe");
	// oe is registered off the state, so it trails start by two edges
	cmd_drive_a: assert property (start_i |-> ##2 cmd_out) else $error("command bytes not driven");
endmodule : asbdc_props
bind asbdc_ctrl asbdc_props u_props (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ubm_req_i(ubm_req_i),
	.ubm_we_i(ubm_we_i), .ubm_gnt_o(ubm_gnt_o), .start_i(start_i), .irq_o(irq_o), .irq_err_o(irq_err_o),
	.drv_oe_o(drv_oe_o), .drv_pio_stb_o(drv_pio_stb_o), .drv_udma_stb_o(drv_udma_stb_o));

//--- bench/asbdc_drive_model.sv
`timescale 1ns/1ps
module asbdc_drive_model (
	input  wire logic       ref_clk_i,
	input  wire logic       clr_i,
	input  wire logic       slow_i,
	input  wire logic       err_i,
	input  wire logic       pio_stb_i,
	input  wire logic       udma_stb_i,
	output logic            rdy_o,
	output logic            err_o,
	output logic [7:0]      din_o,
	output logic [7:0]      pio_n_o,
	output logic [7:0]      udma_n_o
);
	logic [2:0] tick_r;
	always @(posedge ref_clk_i) begin
		tick_r <= clr_i ? 3'h0 : tick_r + 3'h1;
		// a slow drive is ready only one cycle in eight
		rdy_o <= !slow_i || tick_r == 3'h0;
		err_o <= err_i && (pio_n_o != 8'h00 || udma_n_o != 8'h00);
		if (clr_i) begin
			pio_n_o <= 8'h00;
			udma_n_o <= 8'h00;
			din_o <= 8'h3C;
		end else begin
			pio_n_o <= pio_n_o + {7'h00, pio_stb_i};
			udma_n_o <= udma_n_o + {7'h00, udma_stb_i};
			if (pio_stb_i || udma_stb_i) din_o <= din_o + 8'h11;
		end
	end
endmodule : asbdc_drive_model

//--- bench/ata_sector_buffer_dma_controller_tb_top.sv
`timescale 1ns/1ps
module ata_sector_buffer_dma_controller_tb_top;
	logic clk = 0, resetn = 0, ureq = 0, uwe = 0, mwr = 0, mrd = 0, start = 0, clr = 1, slow = 0, derr = 0;
	logic [1:0] size = 2'h2, mgrp = 2'h0;
	logic [14:0] uaddr = 15'h0000;
	logic [7:0] uwd = 8'h00, mwd = 8'h00, rdata, mrdata, din, dout, pn, un;
	logic [4:0] midx = 5'h00;
	logic [3:0] cidx;
	logic ugnt, irq, irqe, rdy, err, oe, pstb, ustb, g;
	logic [7:0] v;
	int mismatches = 0, samples_checked = 0, cyc = 0;
	always #5 clk = ~clk;
	asbdc_ctrl DUT (.ref_clk_i(clk), .resetn_i(resetn), .size_sel_i(size), .ubm_req_i(ureq), .ubm_we_i(uwe),
		.ubm_addr_i(uaddr), .ubm_wdata_i(uwd), .ubm_gnt_o(ugnt), .rdata_o(rdata), .mcu_wr_i(mwr), .mcu_rd_i(mrd),
		.mcu_grp_i(mgrp), .mcu_idx_i(midx), .mcu_wdata_i(mwd), .mcu_rdata_o(mrdata), .start_i(start), .irq_o(irq),
		.irq_err_o(irqe), .drv_rdy_i(rdy), .drv_err_i(err), .drv_din_i(din), .drv_dout_o(dout), .drv_oe_o(oe),
		.drv_pio_stb_o(pstb), .drv_udma_stb_o(ustb), .drv_cmd_idx_o(cidx));
	asbdc_drive_model drive (.ref_clk_i(clk), .clr_i(clr), .slow_i(slow), .err_i(derr), .pio_stb_i(pstb),
		.udma_stb_i(ustb), .rdy_o(rdy), .err_o(err), .din_o(din), .pio_n_o(pn), .udma_n_o(un));
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic ub(input logic w, input logic [14:0] a, input logic [7:0] d);
		@(posedge clk);
		{ureq, uwe, uaddr, uwd} <= {1'b1, w, a, d};
		@(posedge clk);
		ureq <= 1'b0;
		#1 g = ugnt;
		@(posedge clk);
		#1 v = rdata;
	endtask : ub
	task automatic mcu(input logic w, input logic [1:0] gr, input logic [4:0] ix, input logic [7:0] d);
		@(posedge clk);
		{mwr, mrd, mgrp, midx, mwd} <= {w, !w, gr, ix, d};
		@(posedge clk);
		{mwr, mrd} <= 2'h0;
		if (ix == 5'h04 && gr == 2'h2) @(posedge clk);
		#1 v = mrdata;
	endtask : mcu
	task automatic t_size;
		logic [14:0] lim[3] = '{asbdc_pkg::LIM_8K, asbdc_pkg::LIM_24K, asbdc_pkg::LIM_32K};
		for (int s = 0; s < 3; s++) begin
			@(posedge clk);
			size <= s[1:0];
			ub(1'b1, 15'h7F30, 8'hA0 + s[7:0]);
			chk(g, 1);
			ub(1'b0, 15'h7F30 & lim[s], 8'h00);
			chk(v, 8'hA0 + s[7:0]);
		end
		$display("size test done");
	endtask : t_size
	task automatic t_mcu;
		ub(1'b1, 15'h0123, 8'h5A);
		ub(1'b1, 15'h0124, 8'h6B);
		mcu(1'b1, 2'h2, 5'h02, 8'h23);
		mcu(1'b1, 2'h2, 5'h03, 8'h01);
		mcu(1'b0, 2'h2, 5'h04, 8'h00);
		chk(v, 8'h5A);
		mcu(1'b0, 2'h2, 5'h04, 8'h00);
		chk(v, 8'h6B);
		$display("indirect access test done");
	endtask : t_mcu
	task automatic t_xfer(input logic [7:0] mode, input logic e, input logic s, input logic [7:0] c);
		int n = 0;
		for (int i = 0; i < 16; i++) mcu(1'b1, 2'h0, i[4:0], 8'hC0 | i[7:0]);
		mcu(1'b1, 2'h1, 5'h00, mode);
		mcu(1'b1, 2'h1, 5'h01, c);
		mcu(1'b1, 2'h1, 5'h02, 8'h00);
		{clr, derr, slow} <= {1'b0, e, s};
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			#1 chk(dout, 8'hC0 | i[7:0]);
			chk({4'h0, cidx}, i[7:0]);
			chk(oe, 1);
		end
		if (s) begin
			ub(1'b1, 15'h0040, 8'h99);
			chk(g, 0);
		end
		// manual mode: each data-register write is one byte handed to the drive
		if (!mode[2]) begin
			for (int k = 0; k < c; k++) begin
				mcu(1'b1, 2'h2, 5'h04, 8'h70 + k[7:0]);
				chk(dout, 8'h70 + k[7:0]);
			end
		end
		while (irq !== 1'b1 && n < 900) begin
			@(posedge clk);
			#1 n++;
		end
		chk(irq, 1);
		chk(irqe, e);
		if (!e) chk(mode[0] ? un : pn, c);
		if (!e) chk(mode[0] ? pn : un, 8'h00);
		mcu(1'b0, 2'h2, 5'h01, 8'h00);
		chk(v, e);
		clr <= 1'b1;
		$display("transfer test done mode %h", mode);
	endtask : t_xfer
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_size();
		t_mcu();
		t_xfer(8'h05, 1'b0, 1'b0, 8'h04);
		t_xfer(8'h06, 1'b0, 1'b0, 8'h04);
		t_xfer(8'h04, 1'b0, 1'b0, 8'h04);
		t_xfer(8'h0C, 1'b0, 1'b1, 8'h04);
		t_xfer(8'h00, 1'b0, 1'b0, 8'h04);
		// long count so the drive error, seen after the first strobe and the pin sync, lands mid-transfer
		t_xfer(8'h04, 1'b1, 1'b0, 8'h10);
		results();
	end
endmodule : ata_sector_buffer_dma_controller_tb_top
